// file: gbcd_acceptor.sv
// Acceptor side of the three-wire byte handshake
`timescale 1ns/1ps
`default_nettype none
module gbcd_acceptor (
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire logic en_i,
  input wire logic dav_i,
  input wire logic atn_i,
  input wire logic eoi_i,
  input wire logic [7:0] dio_i,
  output logic nrfd_oe_o,
  output logic ndac_oe_o,
  gbcd_byte_if.src rx
);
  gbcd_pkg::gbcd_acc_type state;

  // Ready with NDAC held; capture on DAV, release NDAC until DAV drops
  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      state <= gbcd_pkg::ACC_IDLE;
      nrfd_oe_o <= 1'b0;
      ndac_oe_o <= 1'b0;
      rx.data <= 8'h00;
      rx.atn <= 1'b0;
      rx.eoi <= 1'b0;
      rx.strobe <= 1'b0;
    end
    else
    begin
      rx.strobe <= 1'b0;
      case (state)
        gbcd_pkg::ACC_IDLE:
        begin
          nrfd_oe_o <= 1'b0;
          ndac_oe_o <= en_i;
          if (en_i && dav_i)
          begin
            rx.data <= dio_i;
            rx.atn <= atn_i;
            rx.eoi <= eoi_i;
            rx.strobe <= 1'b1;
            nrfd_oe_o <= 1'b1;
            ndac_oe_o <= 1'b0;
            state <= gbcd_pkg::ACC_HOLD;
          end
        end
        gbcd_pkg::ACC_HOLD:
        begin
          if (!dav_i)
          begin
            nrfd_oe_o <= 1'b0;
            ndac_oe_o <= en_i;
            state <= gbcd_pkg::ACC_IDLE;
          end
        end
        default: state <= gbcd_pkg::ACC_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_accept_releases: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    rx.strobe |-> nrfd_oe_o && !ndac_oe_o)
    else $error("accepted byte without NRFD held and NDAC released");
  a_hold_until_dav: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    (state == gbcd_pkg::ACC_HOLD && dav_i) |=> state == gbcd_pkg::ACC_HOLD && nrfd_oe_o)
    else $error("acceptor left hold while DAV still true");
endmodule // gbcd_acceptor
`default_nettype wire

// file: gbcd_byte_if.sv
// Accepted byte handed from the acceptor to the command decoder
`timescale 1ns/1ps
`default_nettype none
interface gbcd_byte_if;
  logic [7:0] data;
  logic atn;
  logic eoi;
  logic strobe;
  modport src (output data, output atn, output eoi, output strobe);
  modport dst (input data, input atn, input eoi, input strobe);
endinterface
`default_nettype wire

// file: gbcd_ctrl_model.sv
// Bus controller model driving and reading the open-collector bus
`timescale 1ns/1ps
`default_nettype none
module gbcd_ctrl_model (
  input wire logic sys_clk_i,
  input wire logic [7:0] dio_oe_i,
  input wire logic eoi_oe_i,
  input wire logic dav_oe_i,
  input wire logic nrfd_oe_i,
  input wire logic ndac_oe_i,
  output logic [7:0] dio_n_o,
  output logic atn_n_o,
  output logic ifc_n_o,
  output logic ren_n_o,
  output logic eoi_n_o,
  output logic dav_n_o,
  output logic nrfd_n_o,
  output logic ndac_n_o,
  output logic rd_stb_o,
  output logic [8:0] rd_data_o
);
  // ****
  // Line pulls, each line low while any party pulls it
  // ****
  logic [7:0] c_dio = 8'h00;
  logic c_atn = 1'b0;
  logic c_ifc = 1'b0;
  logic c_ren = 1'b0;
  logic c_eoi = 1'b0;
  logic c_dav = 1'b0;
  logic c_nrfd = 1'b0;
  logic c_ndac = 1'b0;
  initial rd_stb_o = 1'b0;
  // Pulled-up wires, so a released line reads high
  assign dio_n_o = ~(c_dio | dio_oe_i);
  assign atn_n_o = ~c_atn;
  assign ifc_n_o = ~c_ifc;
  assign ren_n_o = ~c_ren;
  assign eoi_n_o = ~(c_eoi | eoi_oe_i);
  assign dav_n_o = ~(c_dav | dav_oe_i);
  assign nrfd_n_o = ~(c_nrfd | nrfd_oe_i);
  assign ndac_n_o = ~(c_ndac | ndac_oe_i);
  // ****
  // Handshake tasks
  // ****
  task automatic tick(int n);
    repeat (n) @(posedge sys_clk_i) #1;
  endtask
  // Source one byte; ok low when no acceptor answers
  task automatic put(input logic [7:0] b, input logic a, input logic e, output logic ok);
    int i;
    c_atn = a;
    c_dio = b;
    c_eoi = e;
    tick(6);
    for (i = 0; i < 40 && !(nrfd_n_o && !ndac_n_o); i++) tick(1);
    ok = (i < 40);
    c_dav = ok;
    for (i = 0; i < 40 && !ndac_n_o; i++) tick(1);
    c_dav = 1'b0;
    c_dio = 8'h00;
    c_eoi = 1'b0;
    for (i = 0; i < 40 && ndac_n_o && ok; i++) tick(1);
  endtask
  // Accept one byte as sole listener
  task automatic get();
    int i;
    c_ndac = 1'b1;
    for (i = 0; i < 60 && dav_n_o; i++) tick(1);
    rd_data_o = {~eoi_n_o, ~dio_n_o};
    rd_stb_o = !dav_n_o;
    c_nrfd = 1'b1;
    c_ndac = 1'b0;
    tick(1);
    rd_stb_o = 1'b0;
    for (i = 0; i < 40 && !dav_n_o; i++) tick(1);
    c_nrfd = 1'b0;
  endtask
endmodule // gbcd_ctrl_model
`default_nettype wire

// file: gbcd_decoder.sv
// Device-side bus command decoder with talker and serial poll
`timescale 1ns/1ps
`default_nettype none
module gbcd_decoder (
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire logic [7:0] dio_n_i,
  output logic [7:0] dio_n_o,
  output logic [7:0] dio_oe_o,
  input wire logic atn_n_i,
  input wire logic ifc_n_i,
  input wire logic ren_n_i,
  input wire logic eoi_n_i,
  output logic eoi_n_o,
  output logic eoi_oe_o,
  input wire logic dav_n_i,
  output logic dav_n_o,
  output logic dav_oe_o,
  input wire logic nrfd_n_i,
  output logic nrfd_n_o,
  output logic nrfd_oe_o,
  input wire logic ndac_n_i,
  output logic ndac_n_o,
  output logic ndac_oe_o,
  output logic srq_n_o,
  output logic srq_oe_o,
  input wire logic [4:0] primary_addr_i,
  input wire logic lock_on_ren_i,
  input wire logic srq_req_i,
  input wire logic [7:0] status_byte_i,
  input wire logic [7:0] tx_data_i,
  input wire logic tx_last_i,
  input wire logic tx_valid_i,
  output logic tx_ready_o,
  output logic [7:0] rx_data_o,
  output logic rx_end_o,
  output logic rx_valid_o,
  output logic listener_o,
  output logic talker_o,
  output logic remote_o,
  output logic panel_lock_o,
  output logic local_lock_o,
  output logic spoll_o,
  output logic dev_clear_o,
  output logic trigger_o,
  output logic ifc_o
);
  // ****************************************************************
  // Pin synchronisation and polarity
  // ****************************************************************
  logic [gbcd_pkg::PIN_W-1:0] pins;
  logic [7:0] dio_t;
  logic atn_t, ifc_t, ren_t, eoi_t, dav_t, nrfd_t, ndac_t;
  logic ren_q, srq_req_q, srq_pending, llo;
  logic [6:0] cmd;
  logic [1:0] grp;
  logic cmd_byte, data_byte, do_clear, serviced;
  logic [7:0] src_byte;
  logic src_is_stb;
  logic [1:0] settle;
  gbcd_pkg::gbcd_src_type src_state;
  gbcd_byte_if rx ();

  gbcd_sync #(
    .W(gbcd_pkg::PIN_W),
    .INIT({gbcd_pkg::PIN_W{1'b1}})
  ) u_sync (
    .sys_clk_i(sys_clk_i),
    .srst_i(srst_i),
    .d_i({ndac_n_i, nrfd_n_i, dav_n_i, eoi_n_i, ren_n_i, ifc_n_i, atn_n_i, dio_n_i}),
    .q_o(pins)
  );

  // Low level on a line means true
  assign dio_t = ~pins[7:0];
  assign atn_t = ~pins[gbcd_pkg::PIN_ATN];
  assign ifc_t = ~pins[gbcd_pkg::PIN_IFC];
  assign ren_t = ~pins[gbcd_pkg::PIN_REN];
  assign eoi_t = ~pins[gbcd_pkg::PIN_EOI];
  assign dav_t = ~pins[gbcd_pkg::PIN_DAV];
  assign nrfd_t = ~pins[gbcd_pkg::PIN_NRFD];
  assign ndac_t = ~pins[gbcd_pkg::PIN_NDAC];

  // Accept commands always, data only while listening
  gbcd_acceptor u_acc (
    .sys_clk_i(sys_clk_i),
    .srst_i(srst_i),
    .en_i(atn_t || listener_o),
    .dav_i(dav_t),
    .atn_i(atn_t),
    .eoi_i(eoi_t),
    .dio_i(dio_t),
    .nrfd_oe_o(nrfd_oe_o),
    .ndac_oe_o(ndac_oe_o),
    .rx(rx.src)
  );

  // ****************************************************************
  // Command classification
  // ****************************************************************
  // Own address match within a group
  function automatic logic addr_hit(input logic [6:0] c, input logic [1:0] g,
                                    input logic [4:0] a);
    addr_hit = (c[6:gbcd_pkg::GRP_LSB] == g) && (c[gbcd_pkg::ADDR_W-1:0] == a);
  endfunction

  assign cmd = rx.data[6:0];
  assign grp = cmd[6:gbcd_pkg::GRP_LSB];
  assign cmd_byte = rx.strobe && rx.atn;
  assign data_byte = rx.strobe && !rx.atn && listener_o;
  // Universal or addressed clear
  assign do_clear = cmd_byte && ((cmd == gbcd_pkg::CMD_DCL)
                    || (cmd == gbcd_pkg::CMD_SDC && listener_o));
  // Status byte with service request accepted by the controller
  assign serviced = (src_state == gbcd_pkg::SRC_DAV) && !ndac_t && src_is_stb
                    && src_byte[gbcd_pkg::STB_RQS];

  // ****************************************************************
  // Addressing
  // ****************************************************************
  // Listener and talker state, IFC first
  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i || ifc_t)
    begin
      listener_o <= 1'b0;
      talker_o <= 1'b0;
    end
    else if (cmd_byte && grp == gbcd_pkg::GRP_LISTEN)
    begin
      if (cmd == gbcd_pkg::CMD_UNL)
        listener_o <= 1'b0;
      else if (addr_hit(cmd, gbcd_pkg::GRP_LISTEN, primary_addr_i))
        listener_o <= 1'b1;
    end
    else if (cmd_byte && grp == gbcd_pkg::GRP_TALK)
    begin
      // Untalk first, so address 31 can never alias it into a talk address
      if (cmd == gbcd_pkg::CMD_UNT)
        talker_o <= 1'b0;
      else if (addr_hit(cmd, gbcd_pkg::GRP_TALK, primary_addr_i))
        talker_o <= 1'b1;
      else
        talker_o <= 1'b0; // Other talk address
    end
  end

  // IFC level seen by the user
  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
      ifc_o <= 1'b0;
    else
      ifc_o <= ifc_t;
  end

  // ****************************************************************
  // Remote, lockout, serial poll and requests
  // ****************************************************************
  // Remote follows REN edge, listen address and go to local
  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      ren_q <= 1'b0;
      remote_o <= 1'b0;
      llo <= 1'b0;
    end
    else
    begin
      ren_q <= ren_t;
      if (!ren_t)
      begin
        remote_o <= 1'b0;
        llo <= 1'b0;
      end
      else
      begin
        if (!ren_q)
          remote_o <= 1'b1;
        else if (cmd_byte && cmd == gbcd_pkg::CMD_GTL && listener_o)
          remote_o <= 1'b0;
        else if (cmd_byte && addr_hit(cmd, gbcd_pkg::GRP_LISTEN, primary_addr_i)
                 && cmd != gbcd_pkg::CMD_UNL)
          remote_o <= 1'b1;
        if (cmd_byte && cmd == gbcd_pkg::CMD_LLO)
          llo <= 1'b1;
      end
    end
  end

  // Panel lock by configuration or lockout, local key by lockout
  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      panel_lock_o <= 1'b0;
      local_lock_o <= 1'b0;
    end
    else
    begin
      panel_lock_o <= ren_t && (llo || (remote_o && lock_on_ren_i));
      local_lock_o <= ren_t && llo;
    end
  end

  // Serial poll mode, universal
  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i || do_clear)
      spoll_o <= 1'b0;
    else if (cmd_byte && cmd == gbcd_pkg::CMD_SPE)
      spoll_o <= 1'b1;
    else if (cmd_byte && cmd == gbcd_pkg::CMD_SPD)
      spoll_o <= 1'b0;
  end

  // One-cycle clear and trigger requests; other codes fall through
  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      dev_clear_o <= 1'b0;
      trigger_o <= 1'b0;
    end
    else
    begin
      dev_clear_o <= do_clear;
      trigger_o <= cmd_byte && cmd == gbcd_pkg::CMD_GET && listener_o;
    end
  end

  // Received data with its end mark
  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      rx_data_o <= 8'h00;
      rx_end_o <= 1'b0;
      rx_valid_o <= 1'b0;
    end
    else
    begin
      rx_valid_o <= data_byte;
      if (data_byte)
      begin
        rx_data_o <= rx.data;
        rx_end_o <= rx.eoi;
      end
    end
  end

  // Service request held until polled or device clear; a new request wins
  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      srq_req_q <= 1'b0;
      srq_pending <= 1'b0;
      srq_oe_o <= 1'b0;
    end
    else
    begin
      srq_req_q <= srq_req_i;
      if (srq_req_i && !srq_req_q)
        srq_pending <= 1'b1;
      else if (serviced || do_clear)
        srq_pending <= 1'b0;
      srq_oe_o <= srq_pending;
    end
  end

  // ****************************************************************
  // Source handshake for talker data and status byte
  // ****************************************************************
  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i || atn_t || ifc_t || do_clear)
    begin
      src_state <= gbcd_pkg::SRC_IDLE;
      src_byte <= 8'h00;
      src_is_stb <= 1'b0;
      settle <= 2'h0;
      dio_oe_o <= 8'h00;
      eoi_oe_o <= 1'b0;
      dav_oe_o <= 1'b0;
      tx_ready_o <= 1'b0;
    end
    else
    begin
      tx_ready_o <= 1'b0;
      case (src_state)
        gbcd_pkg::SRC_IDLE:
        begin
          if (talker_o && spoll_o)
          begin
            src_byte <= {status_byte_i[7], srq_pending, status_byte_i[5:0]};
            dio_oe_o <= {status_byte_i[7], srq_pending, status_byte_i[5:0]};
            src_is_stb <= 1'b1;
            settle <= gbcd_pkg::SETTLE_CYC;
            src_state <= gbcd_pkg::SRC_SETTLE;
          end
          else if (talker_o && tx_valid_i)
          begin
            src_byte <= tx_data_i;
            dio_oe_o <= tx_data_i;
            eoi_oe_o <= tx_last_i;
            src_is_stb <= 1'b0;
            tx_ready_o <= 1'b1;
            settle <= gbcd_pkg::SETTLE_CYC;
            src_state <= gbcd_pkg::SRC_SETTLE;
          end
        end
        gbcd_pkg::SRC_SETTLE:
        begin
          if (settle != 2'h0)
            settle <= settle - 2'h1;
          else if (!nrfd_t && ndac_t)
          begin
            dav_oe_o <= 1'b1;
            src_state <= gbcd_pkg::SRC_DAV;
          end
        end
        gbcd_pkg::SRC_DAV:
        begin
          if (!ndac_t)
          begin
            dav_oe_o <= 1'b0;
            dio_oe_o <= 8'h00;
            eoi_oe_o <= 1'b0;
            src_state <= gbcd_pkg::SRC_IDLE;
          end
        end
        default: src_state <= gbcd_pkg::SRC_IDLE;
      endcase
    end
  end

  // Open-collector lines only ever pull low
  always_ff @(posedge sys_clk_i)
  begin
    dio_n_o <= 8'h00;
    eoi_n_o <= 1'b0;
    dav_n_o <= 1'b0;
    nrfd_n_o <= 1'b0;
    ndac_n_o <= 1'b0;
    srq_n_o <= 1'b0;
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);

  a_ifc_idles_both: assert property (ifc_t |=> !listener_o && !talker_o)
    else $error("IFC did not idle talker and listener");
  a_unl_idles_listener: assert property (
    cmd_byte && cmd == gbcd_pkg::CMD_UNL && !ifc_t |=> !listener_o)
    else $error("UNL left listener active");
  a_mla_makes_listener: assert property (cmd_byte && !ifc_t && cmd != gbcd_pkg::CMD_UNL
    && addr_hit(cmd, gbcd_pkg::GRP_LISTEN, primary_addr_i) |=> listener_o)
    else $error("own listen address not taken");
  a_mta_makes_talker: assert property (cmd_byte && !ifc_t && cmd != gbcd_pkg::CMD_UNT
    && addr_hit(cmd, gbcd_pkg::GRP_TALK, primary_addr_i) |=> talker_o)
    else $error("own talk address not taken");
  a_sec_ignored: assert property (cmd_byte && !ifc_t && grp == gbcd_pkg::GRP_SEC
    |=> $stable(listener_o) && $stable(talker_o))
    else $error("secondary byte changed addressing");
  a_get_needs_addr: assert property (cmd_byte && cmd == gbcd_pkg::CMD_GET
    |=> trigger_o == $past(listener_o))
    else $error("trigger does not follow listen addressing");
  a_spe_enters_poll: assert property (cmd_byte && cmd == gbcd_pkg::CMD_SPE
    |=> spoll_o)
    else $error("SPE did not enter serial poll");
  a_atn_no_data: assert property (rx.strobe && rx.atn |=> !rx_valid_o)
    else $error("command byte passed as data");
  a_data_passes: assert property (data_byte
    |=> rx_valid_o && rx_data_o == $past(rx.data) && rx_end_o == $past(rx.eoi))
    else $error("data byte not passed on");
  a_ren_off_local: assert property (!ren_t |=> !remote_o && !local_lock_o)
    else $error("remote kept without REN");
  a_srq_until_poll: assert property ($fell(srq_oe_o)
    |-> $past(serviced, 2) || $past(do_clear, 2))
    else $error("SRQ dropped before service");
  a_dav_waits_ready: assert property ($rose(dav_oe_o) |-> $past(!nrfd_t && ndac_t))
    else $error("DAV asserted before acceptors ready");

  c_serial_poll: cover property (serviced);
  c_data_end: cover property (rx_valid_o && rx_end_o);
  c_trigger: cover property (trigger_o);
  c_clear: cover property (dev_clear_o);
endmodule // gbcd_decoder
`default_nettype wire

// file: gbcd_pkg.sv
// Constants and types shared by the bus command decoder files
package gbcd_pkg;
  // ****************************************************************
  // Command codes, compared on the low seven data lines
  // ****************************************************************
  localparam logic [6:0] CMD_GTL = 7'h01;
  localparam logic [6:0] CMD_SDC = 7'h04;
  localparam logic [6:0] CMD_GET = 7'h08;
  localparam logic [6:0] CMD_LLO = 7'h11;
  localparam logic [6:0] CMD_DCL = 7'h14;
  localparam logic [6:0] CMD_SPE = 7'h18;
  localparam logic [6:0] CMD_SPD = 7'h19;
  localparam logic [6:0] CMD_UNL = 7'h3f;
  localparam logic [6:0] CMD_UNT = 7'h5f;

  // ****************************************************************
  // Command groups held in bits 6:5, address in bits 4:0
  // ****************************************************************
  localparam logic [1:0] GRP_CMD = 2'h0;
  localparam logic [1:0] GRP_LISTEN = 2'h1;
  localparam logic [1:0] GRP_TALK = 2'h2;
  localparam logic [1:0] GRP_SEC = 2'h3;
  localparam int GRP_LSB = 5;
  localparam int ADDR_W = 5;

  // ****************************************************************
  // Bit positions in the synchronised pin vector
  // ****************************************************************
  localparam int PIN_W = 15;
  localparam int PIN_ATN = 8;
  localparam int PIN_IFC = 9;
  localparam int PIN_REN = 10;
  localparam int PIN_EOI = 11;
  localparam int PIN_DAV = 12;
  localparam int PIN_NRFD = 13;
  localparam int PIN_NDAC = 14;

  // ****************************************************************
  // Status byte, timing and state types
  // ****************************************************************
  localparam int STB_RQS = 6;
  localparam int SETTLE_NS = 20;
  localparam int CLK_NS = 10;
  localparam logic [1:0] SETTLE_CYC = 2'((SETTLE_NS + CLK_NS - 1) / CLK_NS);

  typedef enum logic [0:0] {
    ACC_IDLE = 1'b0,
    ACC_HOLD = 1'b1
  } gbcd_acc_type;

  typedef enum logic [1:0] {
    SRC_IDLE = 2'b00,
    SRC_SETTLE = 2'b01,
    SRC_DAV = 2'b10
  } gbcd_src_type;
endpackage

// file: gbcd_sync.sv
// Two-stage synchroniser for the bus pins
`timescale 1ns/1ps
`default_nettype none
module gbcd_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta;

  // First stage feeds only the second stage
  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      meta <= INIT;
      q_o <= INIT;
    end
    else
    begin
      meta <= d_i;
      q_o <= meta;
    end
  end
endmodule // gbcd_sync
`default_nettype wire

// file: gpib_bus_command_decoder_test.sv
// Self-checking bench for the bus command decoder
`timescale 1ns/1ps
`default_nettype none
module gpib_bus_command_decoder_test;
  // ****
  // Signals
  // ****
  logic sys_clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic lock_on_ren_i = 1'b0;
  logic srq_req_i = 1'b0;
  logic tx_last_i = 1'b0;
  logic tx_valid_i = 1'b0;
  logic [4:0] primary_addr_i = 5'h00;
  logic [7:0] status_byte_i = 8'h00;
  logic [7:0] tx_data_i = 8'h00;
  logic [7:0] rx_data_o, dio_n_i, dio_oe_o;
  logic atn_n_i, ifc_n_i, ren_n_i, eoi_n_i, dav_n_i, nrfd_n_i, ndac_n_i, rd_stb, ok;
  logic eoi_oe_o, dav_oe_o, nrfd_oe_o, ndac_oe_o, srq_oe_o, tx_ready_o, rx_end_o, rx_valid_o;
  logic listener_o, talker_o, remote_o, panel_lock_o, local_lock_o, spoll_o, dev_clear_o;
  logic trigger_o, ifc_o;
  logic [8:0] rd_data;
  logic [10:0] exp_q[$];
  int failures = 0;
  int samples_checked = 0;
  int cycles = 0;
  wire [7:0] flags = {listener_o, talker_o, remote_o, panel_lock_o, local_lock_o, spoll_o,
    srq_oe_o, ifc_o};
  wire [12:0] drv_n;
  always #5 sys_clk_i = ~sys_clk_i;
  // ****
  // Design and controller
  // ****
  gbcd_decoder u_dut (.sys_clk_i, .srst_i, .dio_n_i, .dio_n_o(drv_n[7:0]), .dio_oe_o,
    .atn_n_i, .ifc_n_i, .ren_n_i, .eoi_n_i, .eoi_n_o(drv_n[8]), .eoi_oe_o, .dav_n_i,
    .dav_n_o(drv_n[9]), .dav_oe_o, .nrfd_n_i, .nrfd_n_o(drv_n[10]), .nrfd_oe_o, .ndac_n_i,
    .ndac_n_o(drv_n[11]), .ndac_oe_o, .srq_n_o(drv_n[12]),
    .srq_oe_o, .primary_addr_i, .lock_on_ren_i, .srq_req_i, .status_byte_i, .tx_data_i,
    .tx_last_i, .tx_valid_i, .tx_ready_o, .rx_data_o, .rx_end_o, .rx_valid_o, .listener_o,
    .talker_o, .remote_o, .panel_lock_o, .local_lock_o, .spoll_o, .dev_clear_o, .trigger_o,
    .ifc_o);
  gbcd_ctrl_model u_ctl (.sys_clk_i, .dio_oe_i(dio_oe_o), .eoi_oe_i(eoi_oe_o),
    .dav_oe_i(dav_oe_o), .nrfd_oe_i(nrfd_oe_o), .ndac_oe_i(ndac_oe_o), .dio_n_o(dio_n_i),
    .atn_n_o(atn_n_i), .ifc_n_o(ifc_n_i), .ren_n_o(ren_n_i), .eoi_n_o(eoi_n_i),
    .dav_n_o(dav_n_i), .nrfd_n_o(nrfd_n_i), .ndac_n_o(ndac_n_i), .rd_stb_o(rd_stb),
    .rd_data_o(rd_data));
  // ****
  // Helpers
  // ****
  task automatic step(int n);
    repeat (n) @(posedge sys_clk_i) #1;
  endtask
  task automatic chk(string nm, logic [10:0] e, logic [10:0] g);
    samples_checked++;
    if (g !== e)
    begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Oldest note against a seen event; none expected reads as 7ff
  task automatic note(logic [10:0] g);
    if (exp_q.size() == 0)
      chk("event", 11'h7ff, g);
    else
      chk("event", exp_q.pop_front(), g);
  endtask
  task automatic cmd(logic [7:0] b);
    u_ctl.put(b, 1'b1, 1'b0, ok);
  endtask
  task automatic fl(logic [7:0] e);
    chk("flags", {3'h0, e}, {3'h0, flags});
  endtask
  task automatic finish_test();
    if (failures == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Watcher: kind 0 data, 1 clear, 2 trigger, 3 byte read by controller
  always @(posedge sys_clk_i)
  begin
    if (rx_valid_o === 1'b1) note({2'h0, rx_end_o, rx_data_o});
    if (dev_clear_o === 1'b1) note(11'h200);
    if (trigger_o === 1'b1) note(11'h400);
    if (rd_stb === 1'b1) note({2'h3, rd_data});
  end
  // Hang guard
  always @(posedge sys_clk_i)
  begin
    cycles++;
    if (cycles == 8000)
    begin
      failures++;
      finish_test();
    end
  end
  // ****
  // Main sequence
  // ****
  initial
  begin
    logic [7:0] a, t;
    logic [7:0] ign [4];
    int i;
    void'($urandom(32'hf6ee));
    // Address 31 would alias the unlisten and untalk codes
    primary_addr_i = 5'($urandom_range(30));
    a = {3'h1, primary_addr_i};
    t = {3'h2, primary_addr_i};
    ign = '{{3'h3, primary_addr_i}, 8'h05, 8'h09, 8'h15};
    repeat (6) @(posedge sys_clk_i);
    #1;
    srst_i = 1'b0;
    step(3);
    fl(8'h00);
    lock_on_ren_i = 1'b1;
    u_ctl.c_ren = 1'b1;
    cmd({1'b0, gbcd_pkg::CMD_UNL});
    cmd(a);
    fl(8'hb0);
    foreach (ign[i]) cmd(ign[i]);
    fl(8'hb0);
    exp_q.push_back(11'h400);
    cmd({1'b1, gbcd_pkg::CMD_GET});
    exp_q.push_back(11'h200);
    cmd({1'b0, gbcd_pkg::CMD_SDC});
    for (i = 0; i < 4; i++)
    begin
      exp_q.push_back({2'h0, i == 3, 8'($urandom)});
      u_ctl.put(exp_q[exp_q.size() - 1][7:0], 1'b0, i == 3, ok);
    end
    cmd({1'b0, gbcd_pkg::CMD_UNL});
    fl(8'h30);
    lock_on_ren_i = 1'b0;
    step(3);
    fl(8'h20);
    lock_on_ren_i = 1'b1;
    cmd({1'b0, gbcd_pkg::CMD_GET});
    cmd({1'b0, gbcd_pkg::CMD_SDC});
    cmd({1'b0, gbcd_pkg::CMD_GTL});
    fl(8'h30);
    u_ctl.put(8'($urandom), 1'b0, 1'b0, ok);
    chk("refused", 11'h0, {10'h0, ok});
    cmd(a);
    cmd({1'b0, gbcd_pkg::CMD_GTL});
    fl(8'h80);
    cmd({1'b0, gbcd_pkg::CMD_LLO});
    fl(8'h98);
    exp_q.push_back(11'h200);
    cmd({1'b0, gbcd_pkg::CMD_DCL});
    fl(8'h98);
    u_ctl.c_ren = 1'b0;
    step(5);
    fl(8'h80);
    cmd({1'b0, gbcd_pkg::CMD_UNL});
    cmd(t);
    fl(8'h40);
    cmd(t ^ 8'h01);
    fl(8'h00);
    cmd(t);
    u_ctl.c_atn = 1'b0;
    tx_data_i = 8'($urandom);
    tx_last_i = 1'b1;
    tx_valid_i = 1'b1;
    exp_q.push_back({3'h7, tx_data_i});
    for (i = 0; i < 20 && tx_ready_o !== 1'b1; i++) step(1);
    step(1);
    tx_valid_i = 1'b0;
    tx_last_i = 1'b0;
    u_ctl.get();
    srq_req_i = 1'b1;
    step(4);
    fl(8'h42);
    status_byte_i = 8'($urandom);
    cmd({1'b0, gbcd_pkg::CMD_SPE});
    fl(8'h46);
    u_ctl.c_atn = 1'b0;
    exp_q.push_back({3'h6, status_byte_i[7], 1'b1, status_byte_i[5:0]});
    u_ctl.get();
    step(2);
    fl(8'h44);
    srq_req_i = 1'b0;
    cmd({1'b0, gbcd_pkg::CMD_SPD});
    fl(8'h40);
    cmd({1'b0, gbcd_pkg::CMD_UNT});
    fl(8'h00);
    for (i = 0; i < 2; i++)
    begin
      cmd(i == 0 ? a : t);
      u_ctl.c_ifc = 1'b1;
      step(5);
      fl(8'h01);
      u_ctl.c_ifc = 1'b0;
      step(5);
      fl(8'h00);
    end
    step(5);
    chk("pending", 11'h0, 11'(exp_q.size()));
    chk("drive_n", 11'h0, {10'h0, |drv_n});
    finish_test();
  end
endmodule // gpib_bus_command_decoder_test
`default_nettype wire
